/* hw/sprc_consts.vh */
// Purpose: constants for the serial port rate and link control register
// Assumes: 32-bit register at byte offset 0x154, bit 0 is the lsb
// Notes:   bit numbers follow the register layout as printed
`ifndef SPRC_CONSTS_VH
`define SPRC_CONSTS_VH

// ************************************************
// register offsets
// ************************************************
`define SPRC_ADDR_RATE_CTRL   12'h154
`define SPRC_ADDR_LINK_STAT   12'h158

// ************************************************
// field positions
// ************************************************
`define SPRC_RATE_LSB         0
`define SPRC_RATE_MSB         3
`define SPRC_DISC_SUP_BIT     4
`define SPRC_DISC_EN_BIT      5
`define SPRC_SCR_BYP_BIT      29
`define SPRC_EMPH_SUP_BIT     30
`define SPRC_EMPH_EN_BIT      31
`define SPRC_IDLE_SEQ_BIT     2

// ************************************************
// reset values and codes
// ************************************************
`define SPRC_RATE_NONE        4'h0
`define SPRC_RATE_1G25        4'h1
`define SPRC_RATE_2G5         4'h2
`define SPRC_RATE_3G125       4'h3
`define SPRC_RATE_5G          4'h4
`define SPRC_RATE_6G25        4'h5
`define SPRC_SCR_BYP_RST      1'h0
`define SPRC_RESP_OKAY        2'h0
`define SPRC_RESP_SLVERR      2'h2

`endif

/* hw/sprc_top.v */
// Purpose: port rate and link control register with an axi4-lite slave
// Assumes: single clock sys_clk, async active-high reset sys_rst
// Notes:   support flags and enable reset values are build parameters
// Contract
// - bits 3:0 hold the selected line rate, zero after reset.
// - rate codes 1 to 5 mean 1.25, 2.5, 3.125, 5.0 and 6.25 GBaud.
// - bit 4 is a read-only flag for rate discovery support.
// - bit 5 enables rate discovery and cannot be set unsupported.
// - bit 6 flags 1.25 GBaud support and bit 7 enables it if so.
// - bit 8 flags 2.5 GBaud support and bit 9 enables it if so.
// - bit 10 flags 3.125 GBaud support and bit 11 enables it if so.
// - bit 12 flags 5.0 GBaud support and bit 13 enables it if so.
// - bit 14 flags 6.25 GBaud support and bit 15 enables it if so.
// - bit 29 resets to 0 and when 1 bypasses scrambler and descrambler.
// - bit 30 is a read-only flag for remote emphasis support.
// - bit 31 can be set only if bit 30 is 1 and second idle is active.
// - a read-only status bit shows that the second idle is in use.
`timescale 1ns/1ps
`include "sprc_consts.vh"

module sprc_top #(
	parameter [0:0] DISC_SUP  = 1'h1,
	parameter [0:0] DISC_RST  = 1'h0,
	parameter [4:0] RATE_SUP  = 5'h1F,
	parameter [4:0] RATE_RST  = 5'h00,
	parameter [0:0] EMPH_SUP  = 1'h1,
	parameter [0:0] EMPH_RST  = 1'h0
) (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        clk_en,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        second_idle_sequence,
	output reg  [3:0]  rate_sel,
	output reg         disc_en,
	output reg  [4:0]  rate_en,
	output reg         scr_bypass,
	output reg         emph_en
);

	// ************************************************
	// register state
	// ************************************************
	reg  [3:0]  rate_reg;
	reg         disc_reg;
	reg  [4:0]  ren_reg;
	reg         byp_reg;
	reg         emph_reg;
	reg         idle_s1_reg;
	reg         idle_s2_reg;
	reg  [11:0] awaddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	reg         aw_have_reg;
	reg         w_have_reg;

	// ************************************************
	// address decode
	// ************************************************
	// word addresses of the two registers, low two bits ignored
	localparam [11:0] ADDR_CTRL = `SPRC_ADDR_RATE_CTRL;
	localparam [11:0] ADDR_STAT = `SPRC_ADDR_LINK_STAT;
	localparam [1:0]  SLOT_NONE = 2'h0;
	localparam [1:0]  SLOT_CTRL = 2'h1;
	localparam [1:0]  SLOT_STAT = 2'h2;

	// map a byte address onto a register slot, shared by both channels
	function [1:0] sprc_slot;
		input [11:0] addr;
		begin
			if (addr[11:2] == ADDR_CTRL[11:2])
				sprc_slot = SLOT_CTRL;
			else if (addr[11:2] == ADDR_STAT[11:2])
				sprc_slot = SLOT_STAT;
			else
				sprc_slot = SLOT_NONE; // unmapped, answered with an error
		end
	endfunction

	// ************************************************
	// word merge and assembly
	// ************************************************
	// merge a write into a word under byte strobes
	function [31:0] sprc_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer      i;
		begin
			sprc_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					sprc_merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// assemble the control word from state and build flags
	function [31:0] sprc_word;
		input [3:0] rate;
		input       disc;
		input [4:0] ren;
		input       byp;
		input       emph;
		integer     k;
		begin
			sprc_word = 32'h0000_0000; // reserved read zero
			sprc_word[3:0] = rate;
			sprc_word[`SPRC_DISC_SUP_BIT] = DISC_SUP;
			sprc_word[`SPRC_DISC_EN_BIT] = disc;
			for (k = 0; k < 5; k = k + 1) begin
				sprc_word[6 + 2*k] = RATE_SUP[k];
				sprc_word[7 + 2*k] = ren[k];
			end
			sprc_word[`SPRC_SCR_BYP_BIT] = byp;
			sprc_word[`SPRC_EMPH_SUP_BIT] = EMPH_SUP;
			sprc_word[`SPRC_EMPH_EN_BIT] = emph;
		end
	endfunction

	// ************************************************
	// combinational control
	// ************************************************
	wire [31:0] cur_word;
	wire [31:0] new_word;
	wire        do_write;
	wire        hit_ctrl;
	wire        hit_stat;
	wire [1:0]  wr_slot;
	wire [1:0]  rd_slot;
	wire        emph_ok;
	wire [4:0]  ren_new;
	integer     j;
	reg  [4:0]  ren_mask;

	assign cur_word = sprc_word(rate_reg, disc_reg, ren_reg, byp_reg,
		emph_reg);
	assign new_word = sprc_merge(cur_word, wdata_reg, wstrb_reg);
	// a write commits once both halves are held and no answer is pending
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	// decode both addresses once, outside the clocked processes
	assign wr_slot  = sprc_slot(awaddr_reg);
	assign rd_slot  = sprc_slot(s_axi_araddr);
	assign hit_ctrl = (wr_slot == SLOT_CTRL);
	assign hit_stat = (wr_slot == SLOT_STAT);
	// emphasis may be switched on only with support and second idle active
	assign emph_ok  = EMPH_SUP && idle_s2_reg;

	// pick out the five rate enables from the merged word
	always @* begin
		ren_mask = 5'h00;
		for (j = 0; j < 5; j = j + 1)
			ren_mask[j] = new_word[7 + 2*j];
	end
	// enables of unsupported rates are forced to zero
	assign ren_new = ren_mask & RATE_SUP;

	// ************************************************
	// second idle status synchroniser
	// ************************************************
	// only the second stage is read, the first may be metastable
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			idle_s1_reg <= 1'h0;
			idle_s2_reg <= 1'h0;
		end else if (clk_en) begin
			idle_s1_reg <= second_idle_sequence;
			idle_s2_reg <= idle_s1_reg;
		end
	end

	// ************************************************
	// write channel: address and data in either order
	// ************************************************
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'h1;
			s_axi_wready  <= 1'h1;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= `SPRC_RESP_OKAY;
			aw_have_reg   <= 1'h0;
			w_have_reg    <= 1'h0;
			awaddr_reg    <= 12'h000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			rate_reg      <= `SPRC_RATE_NONE;
			disc_reg      <= DISC_RST & DISC_SUP;
			ren_reg       <= RATE_RST & RATE_SUP;
			byp_reg       <= `SPRC_SCR_BYP_RST;
			emph_reg      <= EMPH_RST & EMPH_SUP;
		end else if (clk_en) begin
			// accept address
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg    <= s_axi_awaddr;
				aw_have_reg   <= 1'h1;
				s_axi_awready <= 1'h0;
			end
			// accept data
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
				w_have_reg   <= 1'h1;
				s_axi_wready <= 1'h0;
			end
			// commit write and raise response
			if (do_write) begin
				s_axi_bvalid <= 1'h1;
				aw_have_reg  <= 1'h0;
				w_have_reg   <= 1'h0;
				if (hit_ctrl) begin
					s_axi_bresp <= `SPRC_RESP_OKAY;
					rate_reg <= new_word[3:0];
					disc_reg <= new_word[`SPRC_DISC_EN_BIT] & DISC_SUP;
					ren_reg  <= ren_new;
					byp_reg  <= new_word[`SPRC_SCR_BYP_BIT];
					// set only with support and second idle active
					if (!new_word[`SPRC_EMPH_EN_BIT])
						emph_reg <= 1'h0;
					else if (emph_ok)
						emph_reg <= 1'h1;
				end else if (hit_stat) begin
					s_axi_bresp <= `SPRC_RESP_OKAY; // read-only
				end else begin
					s_axi_bresp <= `SPRC_RESP_SLVERR;
				end
			end
			// response taken, reopen channels; a held answer blocks both
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready  <= 1'h1;
			end
		end
	end

	// ************************************************
	// read channel
	// ************************************************
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SPRC_RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'h0;
				s_axi_rvalid  <= 1'h1;
				// word is captured here and stands until rready
				if (rd_slot == SLOT_CTRL) begin
					s_axi_rdata <= cur_word;
					s_axi_rresp <= `SPRC_RESP_OKAY;
				end else if (rd_slot == SLOT_STAT) begin
					s_axi_rdata <= {29'h0, idle_s2_reg, 2'h0};
					s_axi_rresp <= `SPRC_RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `SPRC_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'h0;
				s_axi_arready <= 1'h1;
			end
		end
	end

	// ************************************************
	// registered control outputs
	// ************************************************
	// every pin trails its register by one cycle and leaves a flop
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rate_sel   <= `SPRC_RATE_NONE;
			disc_en    <= 1'h0;
			rate_en    <= 5'h00;
			scr_bypass <= 1'h0;
			emph_en    <= 1'h0;
		end else if (clk_en) begin
			rate_sel   <= rate_reg;
			disc_en    <= disc_reg;
			rate_en    <= ren_reg;
			scr_bypass <= byp_reg;
			emph_en    <= emph_reg;
		end
	end

endmodule

/* tb/sprc_top_assertions.sv */
// Purpose: concurrent checks on the rate and link control register
// Assumes: bound to sprc_top, one clock domain
// Notes:   helper logic keeps the last accepted read address
`timescale 1ns/1ps
module sprc_chk #(
	parameter [0:0] DISC_SUP = 1'h1,
	parameter [4:0] RATE_SUP = 5'h1F,
	parameter [0:0] EMPH_SUP = 1'h1
) (
	input wire        sys_clk,
	input wire        sys_rst,
	input wire        clk_en,
	input wire [11:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire [3:0]  rate_sel,
	input wire        disc_en,
	input wire [4:0]  rate_en,
	input wire        scr_bypass,
	input wire        emph_en
);
	reg  [11:0] rd_addr_reg;
	wire        ctl_rd = s_axi_rvalid && rd_addr_reg == 12'h154;
	wire        sta_rd = s_axi_rvalid && rd_addr_reg == 12'h158;
	// ************************************************
	// checks
	// ************************************************
	// address of the read now being answered
	always @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			rd_addr_reg <= 12'h000;
		else if (s_axi_arvalid && s_axi_arready && clk_en)
			rd_addr_reg <= s_axi_araddr;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_disc; !disc_en || DISC_SUP; endproperty
	property p_rate; (rate_en & ~RATE_SUP) == 5'h00; endproperty
	property p_emph; $rose(emph_en) |-> EMPH_SUP; endproperty
	property p_resv; ctl_rd |-> s_axi_rdata[28:16] == 13'h0000; endproperty
	property p_flag;
		ctl_rd |-> s_axi_rdata[4] == DISC_SUP && s_axi_rdata[30] == EMPH_SUP
		&& {s_axi_rdata[14], s_axi_rdata[12], s_axi_rdata[10],
		s_axi_rdata[8], s_axi_rdata[6]} == RATE_SUP;
	endproperty
	property p_mirr;
		ctl_rd |-> s_axi_rdata[3:0] == rate_sel &&
		s_axi_rdata[29] == scr_bypass && s_axi_rdata[31] == emph_en;
	endproperty
	property p_stat; sta_rd |-> (s_axi_rdata & 32'hFFFFFFFB) == 32'h0;
	endproperty
	property p_rans; s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
	endproperty
	a_disc: assert property (p_disc) else $error("disc enable");
	a_rate: assert property (p_rate) else $error("rate enable");
	a_emph: assert property (p_emph) else $error("emph enable");
	a_resv: assert property (p_resv) else $error("reserved bits");
	a_flag: assert property (p_flag) else $error("support flags");
	a_mirr: assert property (p_mirr) else $error("control copy");
	a_stat: assert property (p_stat) else $error("status word");
	a_rans: assert property (p_rans) else $error("read answer");
	c_ctl: cover property (ctl_rd);
	c_emph: cover property ($rose(emph_en));
	c_byp: cover property ($rose(scr_bypass));
endmodule
bind sprc_top sprc_chk #(.DISC_SUP(DISC_SUP), .RATE_SUP(RATE_SUP),
	.EMPH_SUP(EMPH_SUP)) i_chk (.*);

/* tb/serial_port_rate_control_register_tb.sv */
// Purpose: self-checking bench for the rate and link control register
// Assumes: axi4-lite master, bready and rready held high
// Notes:   build with some features unsupported to exercise refusals
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons = comparisons + 1; \
	if ((g) !== (e)) begin mismatches = mismatches + 1; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module serial_port_rate_control_register_tb;
	reg         sys_clk = 1'b0;
	reg         sys_rst = 1'b1;
	reg  [11:0] awaddr = 12'h000;
	reg  [11:0] araddr = 12'h000;
	reg  [31:0] wdata = 32'h00000000;
	reg  [3:0]  wstrb = 4'hF;
	reg         awvalid = 1'b0;
	reg         wvalid = 1'b0;
	reg         arvalid = 1'b0;
	reg         second_idle = 1'b0;
	reg         clk_en = 1'b1;
	reg         bready = 1'b0;
	reg         rready = 1'b0;
	wire        awready, wready, bvalid, arready, rvalid;
	wire        disc_en, scr_bypass, emph_en;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [3:0]  rate_sel;
	wire [4:0]  rate_en;
	integer     mismatches = 0;
	integer     comparisons = 0;
	// ************************************************
	// clock, dut and bus tasks
	// ************************************************
	always #4 sys_clk = ~sys_clk;
	sprc_top #(.DISC_SUP(1'h0), .DISC_RST(1'h1), .RATE_SUP(5'h15),
		.RATE_RST(5'h1F)) i_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .second_idle_sequence(second_idle),
		.rate_sel(rate_sel), .disc_en(disc_en), .rate_en(rate_en),
		.scr_bypass(scr_bypass), .emph_en(emph_en));
	task end_of_test;
		begin
			if (mismatches == 0 && comparisons > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// a wait that ran out ends the run
	task tmo(input integer n);
		if (n >= 40) begin
			mismatches = mismatches + 1;
			end_of_test;
		end
	endtask
	task wr(input [11:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
		integer n;
		begin
			awaddr <= a;
			wdata <= d;
			wstrb <= s;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			n = 0;
			do begin
				@(posedge sys_clk);
				n = n + 1;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid && n < 40);
			tmo(n);
			`CHK(bresp, e)
		end
	endtask
	task rd(input [11:0] a, input [31:0] d, input [1:0] e);
		integer n;
		begin
			araddr <= a;
			arvalid <= 1'b1;
			n = 0;
			do begin
				@(posedge sys_clk);
				n = n + 1;
				if (arready) arvalid <= 1'b0;
			end while (!rvalid && n < 40);
			tmo(n);
			`CHK(rdata, d)
			`CHK(rresp, e)
		end
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	task t_reset;
		begin
			rd(12'h154, 32'h4000CCC0, 2'h0);
			rd(12'h158, 32'h00000000, 2'h0);
			`CHK(rate_en, 5'h15)
		end
	endtask
	// codes 0 to 5 and F, enables all written 1, only supported ones stick
	task t_rates;
		integer i;
		reg [3:0] c;
		for (i = 0; i < 7; i = i + 1) begin
			c = (i == 6) ? 4'hF : i[3:0];
			wr(12'h154, 32'h7FFFFFA0 | c, 4'hF, 2'h0);
			rd(12'h154, 32'h6000CCC0 | c, 2'h0);
			`CHK(rate_sel, c)
			`CHK(scr_bypass, 1'b1)
			`CHK(disc_en, 1'b0)
		end
	endtask
	task t_strobe;
		begin
			wr(12'h154, 32'h00000000, 4'h1, 2'h0);
			rd(12'h154, 32'h6000CC40, 2'h0);
			wr(12'h154, 32'h00000000, 4'hF, 2'h0);
			rd(12'h154, 32'h40004440, 2'h0);
			`CHK(scr_bypass, 1'b0)
		end
	endtask
	task t_emph;
		begin
			wr(12'h154, 32'h80000000, 4'hF, 2'h0);
			rd(12'h154, 32'h40004440, 2'h0);
			second_idle <= 1'b1;
			repeat (6) @(posedge sys_clk);
			rd(12'h158, 32'h00000004, 2'h0);
			wr(12'h154, 32'h80000000, 4'hF, 2'h0);
			rd(12'h154, 32'hC0004440, 2'h0);
			`CHK(emph_en, 1'b1)
			wr(12'h154, 32'h00000000, 4'hF, 2'h0);
			@(posedge sys_clk);
			`CHK(emph_en, 1'b0)
		end
	endtask
	task t_err;
		begin
			wr(12'h200, 32'hFFFFFFFF, 4'hF, 2'h2);
			rd(12'h200, 32'h00000000, 2'h2);
			wr(12'h158, 32'hFFFFFFFF, 4'hF, 2'h0);
			rd(12'h154, 32'h40004440, 2'h0);
		end
	endtask
	// clock enable low: a pending write is neither taken nor committed
	task t_freeze;
		begin
			clk_en <= 1'b0;
			awaddr <= 12'h154;
			wdata <= 32'h00000001;
			wstrb <= 4'hF;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			repeat (4) @(posedge sys_clk);
			`CHK(awready, 1'b1)
			`CHK(bvalid, 1'b0)
			`CHK(rate_sel, 4'h0)
			clk_en <= 1'b1;
			wr(12'h154, 32'h00000001, 4'hF, 2'h0);
			rd(12'h154, 32'h40004441, 2'h0);
			`CHK(rate_sel, 4'h1)
		end
	endtask
	// reset in mid-run brings every field back to its reset value
	task t_rerun;
		begin
			second_idle <= 1'b0;
			sys_rst <= 1'b1;
			repeat (2) @(posedge sys_clk);
			sys_rst <= 1'b0;
			@(posedge sys_clk);
			t_reset;
		end
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		bready <= 1'b1;
		rready <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_rates;
		t_strobe;
		t_emph;
		t_err;
		t_freeze;
		t_rerun;
		end_of_test;
	end
endmodule
